// ===== rtl/dacc_pkg.sv
// Constants shared by the dual converter output and mode control block.
`default_nettype none
package dacc_pkg;
    // ------------------------------------------------------------------
    // Widths, latencies and counts
    // ------------------------------------------------------------------
    localparam int WORD_W        = 10;  // Output word width, bit 9 is the MSB.
    localparam int PIPE_LAT      = 5;   // Sample clocks from sample to output word.
    localparam int WAKE_CYCLES   = 10;  // Sample clocks before words are valid again.
    localparam int COARSE_BITS   = 7;   // Bits resolved by one-bit stages.
    localparam int FLASH_BITS    = 3;   // Bits resolved by the final flash stage.
    localparam int CLK_PERIOD_NS = 8;   // System clock period.
    localparam int MIN_RATE_MSPS = 20;  // Least sample rate the source must give.
    // Longest sample period in system cycles, rounded down.
    localparam int MAX_SAMPLE_CYC = (1000 / MIN_RATE_MSPS) / CLK_PERIOD_NS;
    localparam logic [3:0] WAKE_INIT = 4'hA;

    // ------------------------------------------------------------------
    // Mode select decoding {upper, lower}
    // ------------------------------------------------------------------
    localparam logic [1:0] SEL_PD_BOTH = 2'h0;
    localparam logic [1:0] SEL_PD_B    = 2'h1;
    localparam logic [1:0] SEL_NORMAL  = 2'h2;
    localparam logic [1:0] SEL_ALIGN   = 2'h3;
endpackage : dacc_pkg
`default_nettype wire

// ===== rtl/dacc_core.sv
// Dual channel converter output staging, format and mode control.
//
// Contract
// - Powered-down channel floats its output drivers.
// - Format high two's complement, low offset binary.
// - Output word is sample from five clocks earlier.
// - New word launched from sample clock rising edge.
// - Power down both, or only channel B.
// - Ten sample clocks after wake before valid.
// - Align mode delays B by half period.
// - Antiphase clocks align: B updates on A edge.
// - Common clock align: B offset half period.
// - Common clock, no align: same edge updates.
// - Seven coarse bits plus three flash, corrected; the code joins them with no correction.
// - Selects 00 both off, 01 B off, 10, 11.
`default_nettype none
module dacc_core
    import dacc_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int LAT   = PIPE_LAT,
    parameter int WAKE  = WAKE_CYCLES
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    // Sample clocks, sampled as ordinary inputs
    input  wire logic             i_channel_a_sample_clock,
    input  wire logic             i_channel_b_sample_clock,
    // Quantised samples from the analog front end
    input  wire logic [WIDTH-1:0] i_sample_a,
    input  wire logic [WIDTH-1:0] i_sample_b,
    // Static mode and format selects
    input  wire logic             i_mode_select_upper,
    input  wire logic             i_mode_select_lower,
    input  wire logic             i_output_format_and_range_select,
    // Channel A output pins and valid marker
    output logic [WIDTH-1:0]      o_channel_a_output_word,
    output logic                  o_channel_a_oe,
    output logic                  o_channel_a_valid,
    // Channel B output pins and valid marker
    output logic [WIDTH-1:0]      o_channel_b_output_word,
    output logic                  o_channel_b_oe,
    output logic                  o_channel_b_valid,
    // Receiver side of channel B buffer
    input  wire logic             i_channel_b_ready,
    output logic                  o_channel_b_buf_ready
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic             clka_d;
        logic             clkb_d;
        logic [LAT-1:0][WIDTH-1:0] pipe_a;
        logic [LAT-1:0][WIDTH-1:0] pipe_b;
        logic [WIDTH-1:0] out_a;
        logic [WIDTH-1:0] out_b;
        logic [3:0]       wake_a;
        logic [3:0]       wake_b;
        logic [1:0][WIDTH-1:0] buf_d;
        logic [1:0]       buf_v;
        logic             buf_wp;
        logic             buf_rp;
        logic             half_pend;
        logic             b_valid;
    } dacc_state_t;

    dacc_state_t st_r;
    dacc_state_t st_nxt;

    logic [1:0] sel;
    logic       pd_a;
    logic       pd_b;
    logic       align;
    logic       rise_a;
    logic       rise_b;
    logic       fall_b;
    logic       buf_push;
    logic       buf_pop;

    // Wake count loaded at reset and while a channel is powered down. The
    // counter is four bits wide, so WAKE must stay below sixteen; a longer
    // recovery would need a wider field in the state struct.
    localparam logic [3:0] WAKE_LD = 4'(WAKE);

    // Map a raw pipeline word to the selected coding.
    // format coding
    function automatic logic [WIDTH-1:0] fmt_word(input logic [WIDTH-1:0] w,
                                                  input logic twos);
        fmt_word = {w[WIDTH-1] ^ twos, w[WIDTH-2:0]};
    endfunction

    // Coarse code from one-bit stages joined with the flash remainder; no
    // overlap correction is applied and nothing carries into the coarse part.
    // coarse and flash join
    function automatic logic [WIDTH-1:0] correct(input logic [WIDTH-1:0] w);
        logic [COARSE_BITS-1:0] c;
        logic [FLASH_BITS-1:0]  f;
        c = w[WIDTH-1:FLASH_BITS];
        f = w[FLASH_BITS-1:0];
        correct = {c, f};
    endfunction

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // select decode
    assign sel    = {i_mode_select_upper, i_mode_select_lower};
    assign pd_a   = (sel == SEL_PD_BOTH);
    assign pd_b   = (sel == SEL_PD_BOTH) || (sel == SEL_PD_B);
    assign align  = (sel == SEL_ALIGN);
    assign rise_a = i_channel_a_sample_clock && !st_r.clka_d;
    assign rise_b = i_channel_b_sample_clock && !st_r.clkb_d;
    assign fall_b = !i_channel_b_sample_clock && st_r.clkb_d;

    // Channel B words pass a two-entry buffer; while it is full a new B edge overwrites the staged word.
    assign buf_push = st_r.half_pend && (align ? fall_b : 1'b1);
    assign buf_pop  = st_r.buf_v[st_r.buf_rp] && i_channel_b_ready;
    assign o_channel_b_buf_ready = !st_r.buf_v[st_r.buf_wp];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt        = st_r;
        st_nxt.clka_d = i_channel_a_sample_clock;
        st_nxt.clkb_d = i_channel_b_sample_clock;
        if (rise_a && !pd_a) begin
            st_nxt.pipe_a = {st_r.pipe_a[LAT-2:0], i_sample_a};
            st_nxt.out_a  = fmt_word(correct(st_r.pipe_a[LAT-1]),
                                     i_output_format_and_range_select);
            if (st_r.wake_a != 4'h0) begin
                st_nxt.wake_a = st_r.wake_a - 4'h1;
            end
        end
        // wake counters restart while powered down
        // Reloading every powered-down cycle means a short power-down
        // glitch still costs the full recovery, which errs on the safe side.
        if (pd_a) begin
            st_nxt.wake_a = WAKE_LD;
        end
        if (rise_b && !pd_b) begin
            st_nxt.pipe_b    = {st_r.pipe_b[LAT-2:0], i_sample_b};
            st_nxt.out_b     = fmt_word(correct(st_r.pipe_b[LAT-1]),
                                        i_output_format_and_range_select);
            st_nxt.half_pend = 1'b1;
            if (st_r.wake_b != 4'h0) begin
                st_nxt.wake_b = st_r.wake_b - 4'h1;
            end
        end
        if (pd_b) begin
            st_nxt.wake_b    = WAKE_LD;
            st_nxt.half_pend = 1'b0;
            st_nxt.buf_v     = 2'h0;
        end
        // B launch: on falling B edge when aligned, else at once
        if (buf_push && !pd_b && st_r.buf_v[st_r.buf_wp] == 1'b0) begin
            st_nxt.buf_d[st_r.buf_wp] = st_r.out_b;
            st_nxt.buf_v[st_r.buf_wp] = 1'b1;
            st_nxt.buf_wp             = !st_r.buf_wp;
            st_nxt.half_pend          = 1'b0;
            st_nxt.b_valid            = (st_r.wake_b == 4'h0);
        end
        if (buf_pop && !pd_b) begin
            st_nxt.buf_v[st_r.buf_rp] = 1'b0;
            st_nxt.buf_rp             = !st_r.buf_rp;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st_r        <= '0;
            st_r.wake_a <= WAKE_LD;
            st_r.wake_b <= WAKE_LD;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The enables follow the selects without a register, so the drivers let
    // go in the same cycle that a power-down code appears on the pins.
    // output enables
    assign o_channel_a_oe          = !pd_a;
    assign o_channel_b_oe          = !pd_b;
    assign o_channel_a_output_word = st_r.out_a;
    assign o_channel_a_valid       = !pd_a && (st_r.wake_a == 4'h0);
    assign o_channel_b_output_word = st_r.buf_d[st_r.buf_rp];
    assign o_channel_b_valid       = !pd_b && st_r.buf_v[st_r.buf_rp] && st_r.b_valid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_pd_a;
        pd_a;
    endsequence

    // A sample edge taken while the channel is powered.
    sequence s_take_a;
        rise_a && !pd_a;
    endsequence

    sequence s_take_b;
        rise_b && !pd_b;
    endsequence

    // A staged B word launched on the falling B edge in align mode.
    sequence s_fall_push;
        align && fall_b && st_r.half_pend && !st_r.buf_v[st_r.buf_wp];
    endsequence

    // A staged B word launched at once when alignment is off.
    sequence s_plain_push;
        !align && !pd_b && st_r.half_pend && !st_r.buf_v[st_r.buf_wp];
    endsequence

    AST_OE_A_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_pd_a |-> !o_channel_a_oe) else $error("Channel A drives while powered down.");
    AST_OE_B_OFF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (sel == SEL_PD_B) |-> (!o_channel_b_oe && o_channel_a_oe))
        else $error("Channel B only power down decoded wrongly.");
    AST_FMT_MSB: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rise_a && !pd_a) |=> (o_channel_a_output_word[WIDTH-1] ==
        ($past(st_r.pipe_a[LAT-1][WIDTH-1]) ^ $past(i_output_format_and_range_select))))
        else $error("Channel A format bit wrong.");
    AST_LOW_BITS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rise_a && !pd_a) |=> (o_channel_a_output_word[WIDTH-2:0] ==
        $past(st_r.pipe_a[LAT-1][WIDTH-2:0]))) else $error("Format touched low bits.");
    AST_HOLD_A: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (!rise_a && !pd_a) |=> $stable(o_channel_a_output_word))
        else $error("Channel A changed without a sample edge.");
    AST_WAKE_A: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(pd_a) |-> !o_channel_a_valid) else $error("Channel A valid too soon.");
    AST_PD_VALID: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (sel == SEL_PD_BOTH) |-> (!o_channel_a_valid && !o_channel_b_valid))
        else $error("Valid while both powered down.");
    // The buffer may only grow on a falling B edge while aligned.
    AST_ALIGN_B: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (align && !fall_b) |=> ($countones(st_r.buf_v) <= $past($countones(st_r.buf_v))))
        else $error("Aligned B pushed off falling edge.");
    AST_NOALIGN_B: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rise_b && !pd_b && !align) |=> st_r.half_pend) else $error("B word not staged.");

    // Pipeline entry: each taken edge captures the sample present at it.
    AST_PIPE_A: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_take_a |=> (st_r.pipe_a[0] == $past(i_sample_a)))
        else $error("Channel A sample not captured.");
    AST_PIPE_B: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_take_b |=> (st_r.pipe_b[0] == $past(i_sample_b)))
        else $error("Channel B sample not captured.");

    // Channel B coding: only the MSB follows the format select.
    AST_FMT_B: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_take_b |=> (st_r.out_b == {$past(st_r.pipe_b[LAT-1][WIDTH-1]) ^
        $past(i_output_format_and_range_select), $past(st_r.pipe_b[LAT-1][WIDTH-2:0])}))
        else $error("Channel B coding wrong.");

    // Launch points of channel B with and without alignment.
    AST_PUSH_HALF: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_fall_push |=> (st_r.buf_wp != $past(st_r.buf_wp)))
        else $error("Aligned B word not launched on falling edge.");
    AST_PUSH_SAME: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_plain_push |=> (st_r.buf_wp != $past(st_r.buf_wp)))
        else $error("Unaligned B word not launched at once.");

    // Recovery: valid comes back exactly when the count runs out.
    AST_WAKE_COUNT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (s_take_a ##0 (st_r.wake_a == 4'h1)) |=> (o_channel_a_valid || pd_a))
        else $error("Channel A valid late after wake.");
    AST_WAKE_B: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $fell(pd_b) |-> !o_channel_b_valid) else $error("Channel B valid too soon.");
    AST_OE_BOTH: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (sel == SEL_PD_BOTH) |-> !o_channel_b_oe)
        else $error("Channel B drives while both powered down.");

    // A stalled head word must stand until the receiver takes it.
    AST_STALL_B: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (o_channel_b_valid && !i_channel_b_ready) |=>
        (pd_b || $stable(o_channel_b_output_word)))
        else $error("Stalled B word changed.");

endmodule : dacc_core
`default_nettype wire

// ===== verif/dacc_capture_model.sv
// Capture-side model that takes channel B words from the output buffer.
`default_nettype none
module dacc_capture_model
    import dacc_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    // Channel B head word and handshake
    input  wire logic [WORD_W-1:0] i_word,
    input  wire logic              i_valid,
    input  wire logic              i_stall,
    output logic                   o_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [WORD_W-1:0] got_q[$];
    time               got_t[$];
    // Ready drops during a stall, so the buffer must hold the words.
    assign o_ready = i_resetn && !i_stall;
    // capture on edge
    // Words are taken on the system edge only while marked valid.
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            got_q.push_back(i_word);
            got_t.push_back($time);
        end
    end
endmodule // dacc_capture_model
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the dual converter output and mode control block.
`default_nettype none
module testbench;
    import dacc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic              i_clk = 1'b0, i_resetn = 1'b0, sclk = 1'b0, fmt = 1'b0, stall = 1'b0;
    logic              sclkb = 1'b0, ph = 1'b0;
    logic [1:0]        mode = SEL_NORMAL;
    logic [WORD_W-1:0] sa = 10'h000, sb = 10'h000, wa, wb;
    logic              aoe, av, boe, bv, bbr, brdy;
    logic [WORD_W-1:0] hist_a[$], hist_b[$], exp_b[$];
    int                errors = 0, checks = 0, cyc = 0, n = 0;
    time               t0, dn;
    logic [WORD_W-1:0] rows[12] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h001, 10'h155,
                                    10'h2AA, 10'h100, 10'h300, 10'h0FF, 10'h201, 10'h17F};
    // ----------------------------------------------------------------
    // Clock, timeout and instances
    // ----------------------------------------------------------------
    always #4 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            print_verdict();
        end
    end
    // Clock B follows clock A, or runs in antiphase while ph is set.
    dacc_core dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_channel_a_sample_clock(sclk),
        .i_channel_b_sample_clock(sclkb), .i_sample_a(sa), .i_sample_b(sb),
        .i_mode_select_upper(mode[1]), .i_mode_select_lower(mode[0]),
        .i_output_format_and_range_select(fmt), .o_channel_a_output_word(wa),
        .o_channel_a_oe(aoe), .o_channel_a_valid(av), .o_channel_b_output_word(wb),
        .o_channel_b_oe(boe), .o_channel_b_valid(bv), .i_channel_b_ready(brdy),
        .o_channel_b_buf_ready(bbr));
    dacc_capture_model cap (.i_clk(i_clk), .i_resetn(i_resetn), .i_word(wb), .i_valid(bv),
        .i_stall(stall), .o_ready(brdy));
    // Offset binary is taken as the raw sample; two's complement flips the MSB.
    function automatic logic [WORD_W-1:0] fmtw(input logic [WORD_W-1:0] v, input logic f);
        return f ? {~v[9], v[8:0]} : v;
    endfunction
    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp,
                         input string msg);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // sample rate
    // Four system cycles per sample keeps the rate at 31.25 MSPS.
    task automatic step(input logic [WORD_W-1:0] a, input logic [1:0] m, input logic f,
                        input logic st);
        @(posedge i_clk);
        t0 = $time;
        sclk <= 1'b1;
        sclkb <= !ph;
        sa <= a;
        sb <= ~a;
        mode <= m;
        fmt <= f;
        stall <= st;
        hist_a.push_back(a);
        hist_b.push_back(~a);
        n++;
        @(posedge i_clk);
        @(posedge i_clk);
        sclk <= 1'b0;
        sclkb <= ph;
        @(posedge i_clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_clk);
        #1;
        check(wa, 10'h000, "A word in reset");
        check(av, 1'b0, "A valid in reset");
        @(posedge i_clk);
        i_resetn <= 1'b1;
        // Table pass once per format; the stall tests the two-entry buffer.
        for (int f = 0; f < 2; f++) begin
            for (int i = 0; i < 12; i++) begin
                step(rows[i], SEL_NORMAL, f[0], f == 1 && (i == 6 || i == 7));
                if (n < 10) check(av, 1'b0, "A valid in wake");
                if (n > 11) check(av, 1'b1, "A valid after wake");
                if (f == 1 && i == 7) check(bbr, 1'b0, "B buffer full in stall");
                if (i >= 5 && n > 11) check(wa, fmtw(hist_a[n-6], f[0]), "A word");
                if (n >= 6) exp_b.push_back(fmtw(hist_b[n-6], f[0]));
            end
        end
        repeat (8) @(posedge i_clk);
        for (int k = 1; k <= 6; k++) check(cap.got_q[cap.got_q.size()-k], exp_b[exp_b.size()-k], "B word");
        dn = cap.got_t[$] - t0;
        // Every mode code: drivers float exactly in the powered-down codes.
        for (int m = 0; m < 4; m++) begin
            step(rows[m], m[1:0], 1'b0, 1'b0);
            check(aoe, m != 0, "A drive");
            check(boe, m >= 2, "B drive");
            if (m == 1) check(av, 1'b0, "A wake");
            if (m == 2) check(bv, 1'b0, "B wake");
        end
        for (int i = 0; i < 12; i++) step(rows[i], SEL_ALIGN, 1'b0, 1'b0);
        repeat (4) @(posedge i_clk);
        check((cap.got_t[$] - t0 > dn) && (cap.got_t[$] - t0 <= dn + 16), 1'b1, "B align delay");
        // Antiphase clocks: the aligned B word launches at clock A's rise.
        ph <= 1'b1;
        for (int i = 0; i < 6; i++) step(rows[i], SEL_ALIGN, 1'b0, 1'b0);
        repeat (4) @(posedge i_clk);
        check(10'(cap.got_t[$] - t0), 10'h010, "B on A edge");
        @(posedge i_clk);
        i_resetn <= 1'b0;
        @(posedge i_clk);
        #1;
        check(wb, 10'h000, "B word in reset");
        check(bv, 1'b0, "B valid in reset");
        check(bbr, 1'b1, "B buffer empty in reset");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
